// ---- src/clk_power_ctrl_defines.vh ----
// Register map, field positions, reset values and timing counts for clock/power control
`ifndef CLK_POWER_CTRL_DEFINES_VH
`define CLK_POWER_CTRL_DEFINES_VH

// Register offsets (byte addresses, one word each)
`define ADDR_SYSCLK 8'h00
`define ADDR_PLLMUL 8'h04
`define ADDR_STANDBY 8'h08
`define ADDR_HALT 8'h0c
`define ADDR_RELEASE 8'h10
`define ADDR_STATUS 8'h14

// Field positions
`define SWITCH_MODE_BIT 3
`define SLEEP_TO_STANDBY_BIT 7
`define ALLSTOP_EN_BIT 15
`define TIMER8_HALT_BIT 0

// Reset values
`define SYSCLK_RST 8'h00
`define PLLMUL_RST 2'h0
`define STANDBY_RST 8'h4f
`define HALT_RST 16'h0fff
`define RELEASE_RST 16'h0000

// Multiply codes
`define MUL_X1 2'h0
`define MUL_X2 2'h1
`define MUL_X4 2'h2
`define MUL_BAD 2'h3

// Wake wait reload values, one less than the state count
`define WAIT_64 20'h0003f
`define WAIT_512 20'h001ff
`define WAIT_1K 20'h003ff
`define WAIT_2K 20'h007ff
`define WAIT_4K 20'h00fff
`define WAIT_16K 20'h03fff
`define WAIT_32K 20'h07fff
`define WAIT_64K 20'h0ffff
`define WAIT_128K 20'h1ffff
`define WAIT_256K 20'h3ffff
`define WAKE_MAX_STATES 20'h7ffff

// Operating modes
`define MODE_RUN 3'h0
`define MODE_SLEEP 3'h1
`define MODE_ALLSTOP 3'h2
`define MODE_SWSTBY 3'h3
`define MODE_WAKEWAIT 3'h4
`define MODE_HWSTBY 3'h5
`define MODE_RESET 3'h6

`endif

// ---- src/clk_enable_divider.v ----
// Divide-by-2^n clock enable pulse generator
`timescale 1ns/1ns

module clk_enable_divider (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire run,
    input wire [2:0] divSel,
    // Enable out
    output reg tick
);

reg [4:0] count_reg;
wire [4:0] mask;

assign mask = (5'h1f >> (3'h5 - divSel)) & 5'h1f;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        count_reg <= 5'h00;
        tick <= 1'b0;
    end else if (!run) begin
        // Stopped generator makes no ticks
        tick <= 1'b0;
    end else begin
        count_reg <= count_reg + 5'h01;
        tick <= ((count_reg & mask) == mask);
    end
end

endmodule // clk_enable_divider

// ---- src/clk_power_ctrl.v ----
// Clock multiply/divide selection and power-down mode controller
// Functional notes
// - Multiply codes 00,01,10 give x1,x2,x4
// - Multiply factor is one after reset
// - Switch bit 0 defers factor until standby
// - Wake interval follows standby timer select
// - Standby stops generator, loads pending factor
// - Switch bit 1 applies factor immediately
// - System clock divides by 1..32
// - Reset leaves high-speed mode, units 0..11 stopped
// - Sleep CPU, division CPU+masters, halt peripherals
// - Halted-retained units keep state, stop running
// - Halted-reset units return to reset values
// - Module stop halts only flagged peripherals
// - All-stop keeps timer8 per its halt bit
// - Sleep wake: NMI, IRQs, watchdog, timer8
// - Standby wake: NMI or enabled IRQ only
// - Wake only on accepted interrupt
// - Standby pin low forces hardware standby
// - Reset pin low resets except hw standby
// - Divide select 000..101, 11X forbidden
// - Switch mode select bit 3, reset 0
// - Wait code 1111 is 524288 states
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "clk_power_ctrl_defines.vh"

module clk_power_ctrl (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port
    input wire [7:0] addr,
    input wire [15:0] wrData,
    input wire wrEn,
    input wire rdEn,
    output reg [15:0] rdData,
    // Pins
    input wire hwStandbyPin_n,
    input wire resetPin_n,
    // Sleep request and wake sources
    input wire sleepReq,
    input wire nmiAccepted,
    input wire [15:0] extIrqAccepted,
    input wire watchdogIrqAccepted,
    input wire timer8IrqAccepted,
    // Clock outputs
    output reg [1:0] pllMult,
    output reg clockGenRun,
    output reg sysTick,
    // Unit controls
    output reg cpuHalt,
    output reg [15:0] moduleHalt,
    output reg [15:0] moduleReset,
    output reg [2:0] opMode
);

// ---------------------------------------------------------------
// Pin synchronisers
// ---------------------------------------------------------------
reg stbySync1_reg;
reg stbySync2_reg;
reg resSync1_reg;
reg resSync2_reg;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        stbySync1_reg <= 1'b1;
        stbySync2_reg <= 1'b1;
        resSync1_reg <= 1'b1;
        resSync2_reg <= 1'b1;
    end else begin
        stbySync1_reg <= hwStandbyPin_n;
        stbySync2_reg <= stbySync1_reg;
        resSync1_reg <= resetPin_n;
        resSync2_reg <= resSync1_reg;
    end
end

wire hwStby = ~stbySync2_reg;
wire pinReset = ~resSync2_reg;

// ---------------------------------------------------------------
// Registers
// ---------------------------------------------------------------
reg [7:0] sysClk_reg;
reg [1:0] pendMult_reg;
reg [1:0] effMult_reg;
reg [7:0] standby_reg;
reg [15:0] halt_reg;
reg [15:0] release_reg;
reg [2:0] mode_reg;
reg [2:0] mode_next;
reg [19:0] wait_reg;

// Writes outside run are dropped; the CPU is halted there anyway
wire regWr = wrEn && (mode_reg == `MODE_RUN);
wire switchNow = sysClk_reg[`SWITCH_MODE_BIT];
wire [3:0] waitSel = standby_reg[3:0];
wire pinForce = hwStby || pinReset;

// Wait length per select code, not a power series
// Reserved codes below 5 fall back to the shortest wait
function [19:0] wait_states;
    input [3:0] code;
    begin
        case (code)
            4'h6: wait_states = `WAIT_512;
            4'h7: wait_states = `WAIT_1K;
            4'h8: wait_states = `WAIT_2K;
            4'h9: wait_states = `WAIT_4K;
            4'ha: wait_states = `WAIT_16K;
            4'hb: wait_states = `WAIT_32K;
            4'hc: wait_states = `WAIT_64K;
            4'hd: wait_states = `WAIT_128K;
            4'he: wait_states = `WAIT_256K;
            4'hf: wait_states = `WAKE_MAX_STATES;
            default: wait_states = `WAIT_64;
        endcase
    end
endfunction

always @(posedge clk or posedge rst) begin
    if (rst) begin
        sysClk_reg <= `SYSCLK_RST;
        pendMult_reg <= `PLLMUL_RST;
        standby_reg <= `STANDBY_RST;
        halt_reg <= `HALT_RST;
        release_reg <= `RELEASE_RST;
    end else if (pinForce) begin
        sysClk_reg <= `SYSCLK_RST;
        pendMult_reg <= `PLLMUL_RST;
        standby_reg <= `STANDBY_RST;
        halt_reg <= `HALT_RST;
        release_reg <= `RELEASE_RST;
    end else if (regWr) begin
        case (addr)
            `ADDR_SYSCLK: begin
                if (wrData[2:1] != 2'h3)
                    sysClk_reg <= {wrData[7], 3'h0, wrData[3:0]};
                else
                    sysClk_reg <= {wrData[7], 3'h0, wrData[3], sysClk_reg[2:0]};
            end
            `ADDR_PLLMUL: begin
                if (wrData[1:0] != `MUL_BAD)
                    pendMult_reg <= wrData[1:0];
            end
            `ADDR_STANDBY: standby_reg <= {wrData[7:6], 2'h0, wrData[3:0]};
            `ADDR_HALT: halt_reg <= wrData;
            `ADDR_RELEASE: release_reg <= wrData;
            default: ;
        endcase
    end
end

// ---------------------------------------------------------------
// Effective multiply factor
// ---------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        effMult_reg <= `MUL_X1;
    end else if (pinForce) begin
        // Pin reset or hardware standby falls back to x1
        effMult_reg <= `MUL_X1;
    end else if (switchNow) begin
        effMult_reg <= pendMult_reg;
    end else if (mode_reg == `MODE_SWSTBY) begin
        effMult_reg <= pendMult_reg;
    end
end

// ---------------------------------------------------------------
// Mode state machine
// ---------------------------------------------------------------
wire irqEnabled = |(extIrqAccepted & release_reg);
wire sleepWake = nmiAccepted || (|extIrqAccepted) || watchdogIrqAccepted
    || (timer8IrqAccepted && !halt_reg[`TIMER8_HALT_BIT]);
wire stbyWake = nmiAccepted || irqEnabled;
wire allStopOk = halt_reg[`ALLSTOP_EN_BIT] && (&halt_reg[14:1]);

always @* begin
    mode_next = mode_reg;
    case (mode_reg)
        `MODE_RUN: begin
            if (sleepReq) begin
                if (standby_reg[`SLEEP_TO_STANDBY_BIT])
                    mode_next = `MODE_SWSTBY;
                else if (allStopOk)
                    mode_next = `MODE_ALLSTOP;
                else
                    mode_next = `MODE_SLEEP;
            end
        end
        `MODE_SLEEP, `MODE_ALLSTOP: begin
            if (sleepWake)
                mode_next = `MODE_RUN;
        end
        `MODE_SWSTBY: begin
            if (stbyWake)
                mode_next = `MODE_WAKEWAIT;
        end
        `MODE_WAKEWAIT: begin
            if (wait_reg == 20'h00000)
                mode_next = `MODE_RUN;
        end
        `MODE_HWSTBY: mode_next = `MODE_RESET;
        `MODE_RESET: mode_next = `MODE_RUN;
        default: mode_next = `MODE_RUN;
    endcase
    if (pinReset && mode_reg != `MODE_HWSTBY)
        mode_next = `MODE_RESET;
    if (hwStby)
        mode_next = `MODE_HWSTBY;
    else if (mode_reg == `MODE_HWSTBY && pinReset)
        mode_next = `MODE_HWSTBY;
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        mode_reg <= `MODE_RUN;
        wait_reg <= 20'h00000;
    end else begin
        mode_reg <= mode_next;
        // Reloaded all through standby, so a late select change counts
        if (mode_reg == `MODE_SWSTBY)
            wait_reg <= wait_states(waitSel);
        else if (mode_reg == `MODE_WAKEWAIT && sysTick && wait_reg != 20'h00000)
            wait_reg <= wait_reg - 20'h00001;
    end
end

// ---------------------------------------------------------------
// System clock enable
// ---------------------------------------------------------------
wire genRun = (mode_reg != `MODE_SWSTBY) && (mode_reg != `MODE_HWSTBY);
wire tick;

clk_enable_divider divider (
    .clk(clk),
    .rst(rst),
    .run(genRun),
    .divSel(sysClk_reg[2:0]),
    .tick(tick)
);

// ---------------------------------------------------------------
// Unit control outputs
// ---------------------------------------------------------------
reg [15:0] haltNext;
reg [15:0] resetNext;
reg cpuHaltNext;

always @* begin
    haltNext = 16'h0000;
    resetNext = 16'h0000;
    cpuHaltNext = 1'b0;
    case (mode_reg)
        `MODE_RUN: begin
            haltNext = {1'b0, halt_reg[14:0]};
            resetNext = {12'h000, halt_reg[3:1], 1'b0};
        end
        `MODE_SLEEP: begin
            cpuHaltNext = 1'b1;
            haltNext = {1'b0, halt_reg[14:0]};
            resetNext = {12'h000, halt_reg[3:1], 1'b0};
        end
        `MODE_ALLSTOP: begin
            cpuHaltNext = 1'b1;
            haltNext = {1'b0, 14'h3fff, halt_reg[`TIMER8_HALT_BIT]};
            resetNext = 16'h000e;
        end
        `MODE_SWSTBY, `MODE_WAKEWAIT: begin
            // retained halt, serial and ADC reset
            cpuHaltNext = 1'b1;
            haltNext = 16'h7fff;
            resetNext = 16'h004e;
        end
        `MODE_HWSTBY, `MODE_RESET: begin
            cpuHaltNext = 1'b1;
            haltNext = 16'h7fff;
            resetNext = 16'h7fff;
        end
        default: ;
    endcase
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        pllMult <= `MUL_X1;
        clockGenRun <= 1'b1;
        sysTick <= 1'b0;
        cpuHalt <= 1'b0;
        moduleHalt <= 16'h0000;
        moduleReset <= 16'h0000;
        opMode <= `MODE_RUN;
    end else begin
        pllMult <= effMult_reg;
        clockGenRun <= genRun;
        sysTick <= tick;
        cpuHalt <= cpuHaltNext;
        moduleHalt <= haltNext;
        moduleReset <= resetNext;
        opMode <= mode_reg;
    end
end

// ---------------------------------------------------------------
// Read port
// ---------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        rdData <= 16'h0000;
    end else if (rdEn) begin
        case (addr)
            `ADDR_SYSCLK: rdData <= {8'h00, sysClk_reg};
            `ADDR_PLLMUL: rdData <= {14'h0000, pendMult_reg};
            `ADDR_STANDBY: rdData <= {8'h00, standby_reg};
            `ADDR_HALT: rdData <= halt_reg;
            `ADDR_RELEASE: rdData <= release_reg;
            `ADDR_STATUS: rdData <= {9'h000, genRun, effMult_reg, 1'b0, mode_reg};
            default: rdData <= 16'h0000;
        endcase
    end else begin
        rdData <= 16'h0000;
    end
end

endmodule // clk_power_ctrl

// ---- tb/clk_power_ctrl_chk.sv ----
// Concurrent checks on the clock and power-down controller ports
`timescale 1ns/1ns

module clk_power_ctrl_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [15:0] wrData,
    input wire logic wrEn,
    // Pins and wake
    input wire logic hwStandbyPin_n,
    input wire logic resetPin_n,
    input wire logic nmiAccepted,
    // Observed outputs
    input wire logic [1:0] pllMult,
    input wire logic clockGenRun,
    input wire logic cpuHalt,
    input wire logic [2:0] opMode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Shadow of switch mode bit
    // ----------------------------------------
    logic switchMode_reg;

    // Pin resets reinitialise registers, so the shadow follows
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            switchMode_reg <= 1'b0;
        end else if (opMode == 3'h5 || opMode == 3'h6) begin
            switchMode_reg <= 1'b0;
        end else if (wrEn && addr == 8'h00 && opMode == 3'h0) begin
            switchMode_reg <= wrData[3];
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_mulWrite;
        wrEn && addr == 8'h04 && wrData[1:0] != 2'h3 && opMode == 3'h0;
    endsequence

    property p_mulNow;
        s_mulWrite ##0 switchMode_reg |-> ##3 pllMult == $past(wrData[1:0], 3);
    endproperty
    property p_mulDefer;
        s_mulWrite ##0 !switchMode_reg |=> $stable(pllMult)[*4];
    endproperty
    property p_badCode;
        pllMult != 2'h3;
    endproperty
    property p_resetState;
        $fell(rst) |-> opMode == 3'h0 && pllMult == 2'h0 && clockGenRun && !cpuHalt;
    endproperty
    property p_sleepCpu;
        opMode == 3'h1 |-> cpuHalt && clockGenRun;
    endproperty
    property p_standbyStop;
        opMode == 3'h3 || opMode == 3'h5 |-> !clockGenRun;
    endproperty
    property p_standbyNmi;
        opMode == 3'h3 && nmiAccepted |-> ##[1:3] opMode == 3'h4;
    endproperty
    property p_wakeWait;
        $rose(opMode == 3'h4) |-> (opMode == 3'h4)[*8];
    endproperty
    property p_hwStandby;
        (!hwStandbyPin_n)[*8] |-> opMode == 3'h5 && !clockGenRun;
    endproperty
    property p_resetPin;
        (!resetPin_n && hwStandbyPin_n)[*8] |-> opMode == 3'h6;
    endproperty

    a_mulNow: assert property (p_mulNow) else $error("Factor not applied at once");
    a_mulDefer: assert property (p_mulDefer) else $error("Deferred factor applied");
    a_badCode: assert property (p_badCode) else $error("Forbidden factor in use");
    a_resetState: assert property (p_resetState) else $error("Bad state after reset");
    a_sleepCpu: assert property (p_sleepCpu) else $error("Sleep halts more than CPU");
    a_standbyStop: assert property (p_standbyStop) else $error("Generator runs in standby");
    a_standbyNmi: assert property (p_standbyNmi) else $error("No wake wait after NMI");
    a_wakeWait: assert property (p_wakeWait) else $error("Wake wait too short");
    a_hwStandby: assert property (p_hwStandby) else $error("No hardware standby");
    a_resetPin: assert property (p_resetPin) else $error("No reset state on pin");
endmodule // clk_power_ctrl_chk

bind clk_power_ctrl clk_power_ctrl_chk clk_power_ctrl_chk_inst (.*);

// ---- tb/tb_clk_power_ctrl.sv ----
// Self-checking testbench for the clock and power-down controller
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) bad($sformatf("%h vs %h", a, b)); end

module tb_clk_power_ctrl;
    logic clk = 0, rst = 1, wrEn = 0, rdEn = 0, hwStandbyPin_n = 1, resetPin_n = 1;
    logic sleepReq = 0, nmiAccepted = 0, watchdogIrqAccepted = 0, timer8IrqAccepted = 0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wrData = 16'h0000, extIrqAccepted = 16'h0000;
    logic [15:0] rdData, moduleHalt, moduleReset;
    logic [1:0] pllMult;
    logic [2:0] opMode;
    logic clockGenRun, sysTick, cpuHalt;
    int errorCnt = 0, checked = 0, n, k;
    int src [4] = '{1, 2, 4, 19};
    // Reset values, last row an unmapped hole
    logic [7:0] rowAddr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    logic [15:0] rowData [7] = '{16'h0000, 16'h0000, 16'h004f, 16'h0fff, 16'h0000, 16'h0040,
        16'h0000};

    clk_power_ctrl clk_power_ctrl_inst (.*);

    always #4 clk = ~clk;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic bad(input string s);
        errorCnt++;
        $display("ERROR %0t %s", $time, s);
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        `CHK(rdData, e)
    endtask
    // Source 0 is the sleep request, the rest are accepted interrupts
    task automatic pulse(input int s);
        @(posedge clk);
        sleepReq <= (s == 0);
        nmiAccepted <= (s == 1);
        watchdogIrqAccepted <= (s == 2);
        timer8IrqAccepted <= (s == 3);
        extIrqAccepted <= (s >= 4) ? 16'h0001 << (s - 4) : 16'h0000;
        @(posedge clk);
        {sleepReq, nmiAccepted, watchdogIrqAccepted, timer8IrqAccepted} <= 4'h0;
        extIrqAccepted <= 16'h0000;
    endtask
    task automatic report_and_stop;
        $display("Errors %0d in %0d checks", errorCnt, checked);
        if (errorCnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(rowAddr[i], rowData[i]);
        end
        wr(8'h00, 16'h0008);
        for (int i = 1; i < 5; i++) begin
            wr(8'h04, 16'(i % 3));
            tick(4);
            `CHK(pllMult, 2'(i % 3))
        end
        wr(8'h04, 16'h0003);
        tick(4);
        `CHK(pllMult, 2'h1)
        // Code 6 is forbidden, so the divide by 32 must survive it
        for (int d = 0; d < 7; d++) begin
            wr(8'h00, 16'(d));
            tick(4);
            n = 0;
            repeat (64) begin
                @(posedge clk);
                #1;
                n += (sysTick === 1'b1);
            end
            `CHK(n, 64 >> ((d == 6) ? 5 : d))
        end
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'h0002);
        tick(6);
        `CHK(pllMult, 2'h1)
        wr(8'h10, 16'h0004);
        wr(8'h08, 16'h00c6);
        pulse(0);
        tick(3);
        `CHK({opMode, clockGenRun, pllMult}, 6'h1a)
        pulse(4);
        tick(4);
        `CHK(opMode, 3'h3)
        pulse(6);
        k = 0;
        while (opMode !== 3'h0 && k < 3000) begin
            @(posedge clk);
            #1;
            k++;
        end
        `CHK(k >= 512 && k < 520, 1'b1)
        `CHK({clockGenRun, pllMult}, 3'h6)
        pulse(0);
        tick(3);
        pulse(1);
        tick(3);
        `CHK(opMode, 3'h4)
        tick(520);
        `CHK(opMode, 3'h0)
        wr(8'h08, 16'h0045);
        foreach (src[i]) begin
            pulse(0);
            tick(3);
            `CHK({opMode, cpuHalt, clockGenRun}, 5'h07)
            pulse(src[i]);
            tick(4);
            `CHK({opMode, cpuHalt}, 4'h0)
        end
        // Timer interrupt is no wake source while its halt bit is set
        pulse(0);
        pulse(3);
        tick(4);
        `CHK(opMode, 3'h1)
        pulse(1);
        wr(8'h0c, 16'hfffe);
        pulse(0);
        tick(3);
        `CHK({opMode, moduleHalt}, 19'h27ffe)
        pulse(3);
        tick(4);
        `CHK(opMode, 3'h0)
        wr(8'h0c, 16'h000e);
        tick(3);
        `CHK({moduleReset[3:0], moduleHalt[0]}, 5'h1c)
        wr(8'h0c, 16'h0001);
        tick(3);
        `CHK({moduleHalt[1:0], moduleReset[0]}, 3'h2)
        @(posedge clk) resetPin_n <= 1'b0;
        tick(10);
        `CHK(opMode, 3'h6)
        @(posedge clk) resetPin_n <= 1'b1;
        tick(12);
        `CHK({opMode, cpuHalt, pllMult}, 6'h00)
        rd(8'h0c, 16'h0fff);
        @(posedge clk) hwStandbyPin_n <= 1'b0;
        tick(10);
        `CHK({opMode, clockGenRun}, 4'ha)
        @(posedge clk) hwStandbyPin_n <= 1'b1;
        tick(20);
        `CHK(opMode, 3'h0)
        wr(8'h00, 16'h0008);
        wr(8'h04, 16'h0001);
        @(posedge clk) rst <= 1'b1;
        tick(3);
        @(posedge clk) rst <= 1'b0;
        tick(2);
        `CHK({opMode, pllMult}, 5'h00)
        report_and_stop;
    end

    // Run needs about 1800 cycles; eleven times that means a hang
    initial begin
        #160000;
        errorCnt++;
        report_and_stop;
    end
endmodule // tb_clk_power_ctrl
